/* File: rtl/eqfir_pkg.sv */
// package for the nine-tap equalizer filter: register map, field layout, modes
// assumes a 32-bit Avalon-MM slave port on one 100 MHz clock
//
// Functional notes
// [R1] optional equalizer filter on converter output samples
// [R2] mode field plus share/merge select filter mode
// [R3] dual-channel mode needs dual link mode, independent filters
// [R4] center tap 18 bits, lsb weight 2^-16
// [R5] other taps 12 bits, lsb 2^-10 to 2^-16
// [R6] one shared weight for all non-center taps
// [R7] single-channel mode needs single link mode, one filter
// [R8] time-varying mode alternates sets every sample, dual-input
// [R9] each set has nine independent coefficients
// [R10] software loads coefficients before enabling a mode
// [R11] full internal precision, round only at output
// [R12] round half to even, then saturate
// [R13] one output per input, fixed latency, bypass
package eqfir_pkg;
    localparam int EQFIR_TAPS = 9;
    localparam int EQFIR_CENTER = 4;
    localparam int EQFIR_SW = 12;
    localparam int EQFIR_CW = 18;
    localparam int EQFIR_NW = 12;
    localparam int EQFIR_CFRAC = 16;
    localparam int EQFIR_NFRAC_MIN = 10;
    localparam int EQFIR_NFRAC_MAX = 16;
    localparam int EQFIR_AW = 8;
    localparam int EQFIR_LAT = 3;
    // register byte offsets
    localparam logic [7:0] EQFIR_OFS_CTRL = 8'h00;
    localparam logic [7:0] EQFIR_OFS_STATUS = 8'h04;
    localparam logic [7:0] EQFIR_OFS_COEF_A = 8'h40;
    localparam logic [7:0] EQFIR_OFS_COEF_B = 8'h80;
    // control field positions
    localparam int EQFIR_MODE_LSB = 0;
    localparam int EQFIR_SHARE_BIT = 4;
    localparam int EQFIR_MERGE_BIT = 5;
    localparam int EQFIR_SHIFT_LSB = 8;
    localparam int EQFIR_LINK_LSB = 12;
    localparam int EQFIR_SINGLE_BIT = 14;
    localparam logic [1:0] EQFIR_MODE_OFF = 2'h0;
    localparam logic [1:0] EQFIR_MODE_ON = 2'h2;
    localparam logic [1:0] EQFIR_LINK_DUAL = 2'h0;
    localparam logic [1:0] EQFIR_LINK_SINGLE = 2'h1;
    localparam logic [2:0] EQFIR_SHIFT_RST = 3'h0;
    localparam logic [31:0] EQFIR_UNMAPPED = 32'hDEADBEEF;

    typedef enum logic [3:0] {
        EQ_BYPASS = 4'b0001,
        EQ_DUAL = 4'b0010,
        EQ_SINGLE = 4'b0100,
        EQ_TVAR = 4'b1000
    } eqfir_mode_t;

    typedef struct packed {
        logic valid;
        logic signed [EQFIR_SW-1:0] a;
        logic signed [EQFIR_SW-1:0] b;
    } eqfir_smp_t;
endpackage

/* File: rtl/eqfir_round.sv */
// round-half-even and saturate of a full-precision accumulator
// assumes the caller gives the fractional bit count as a parameter
`timescale 1ns/1ps
module eqfir_round import eqfir_pkg::*; #(
    parameter int IW = 36,
    parameter int FRAC = 16,
    parameter int OW = 12
) (
    input wire logic signed [IW-1:0] i_acc,
    output logic signed [OW-1:0] o_res
);
    logic signed [IW-1:0] trunc;
    logic signed [IW-1:0] up;
    logic rem_half;
    logic rem_above;
    logic odd;
    localparam logic signed [IW-1:0] MAXV = IW'((1 <<< (OW - 1)) - 1);
    localparam logic signed [IW-1:0] MINV = -IW'(1 <<< (OW - 1));

    always_comb begin
        trunc = i_acc >>> FRAC;
        rem_half = i_acc[FRAC-1];
        rem_above = |i_acc[FRAC-2:0];
        odd = trunc[0];
        // ties go to the even code so no dc bias builds up
        up = (rem_half && (rem_above || odd)) ? trunc + IW'(1) : trunc; // [R12]
        if (up > MAXV) begin
            o_res = MAXV[OW-1:0]; // [R12]
        end else if (up < MINV) begin
            o_res = MINV[OW-1:0];
        end else begin
            o_res = up[OW-1:0];
        end
    end
endmodule // eqfir_round

/* File: rtl/eqfir_tap.sv */
// one nine-tap dot product on a delay line with exact products
// assumes coefficients already aligned to a 2^-16 grid by the caller
`timescale 1ns/1ps
module eqfir_tap import eqfir_pkg::*; #(
    parameter int SW = EQFIR_SW,
    parameter int KW = EQFIR_CW + EQFIR_NFRAC_MAX - EQFIR_NFRAC_MIN,
    parameter int AW = SW + KW + 4
) (
    input wire logic signed [SW-1:0] i_x [EQFIR_TAPS],
    input wire logic signed [KW-1:0] i_k [EQFIR_TAPS],
    output logic signed [AW-1:0] o_sum
);
    logic signed [AW-1:0] prod [EQFIR_TAPS];

    genvar g;
    generate
        for (g = 0; g < EQFIR_TAPS; g++) begin : g_mul
            // no truncation of products or partial sums
            assign prod[g] = AW'(i_x[g]) * AW'(i_k[g]); // [R11]
        end
    endgenerate

    always_comb begin
        o_sum = '0;
        for (int t = 0; t < EQFIR_TAPS; t++) begin
            o_sum = o_sum + prod[t];
        end
    end
endmodule // eqfir_tap

/* File: rtl/eqfir_top.sv */
// nine-tap equalizer on a two-lane sample stream with an avalon-mm slave
// assumes samples arrive on I_CLK from same-clock logic, at most one per cycle
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module eqfir_top import eqfir_pkg::*; #(
    parameter int SW = EQFIR_SW
) (
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic [EQFIR_AW-1:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    output logic [1:0] O_AVS_RESPONSE,
    input wire eqfir_smp_t I_SMP,
    output eqfir_smp_t O_SMP
);
    localparam int KW = EQFIR_CW + EQFIR_NFRAC_MAX - EQFIR_NFRAC_MIN;
    localparam int AW = SW + KW + 4;

    // ==========================================================
    // register file
    // ==========================================================
    logic [1:0] filter_mode_select_q, filter_mode_select_d;
    logic coeff_share_q, coeff_share_d;
    logic channel_merge_q, channel_merge_d;
    logic [2:0] shift_q, shift_d;
    logic [1:0] link_mode_select_q, link_mode_select_d;
    logic single_input_q, single_input_d;
    logic signed [EQFIR_CW-1:0] coeff_regs_chan_a_q [EQFIR_TAPS];
    logic signed [EQFIR_CW-1:0] coeff_regs_chan_a_d [EQFIR_TAPS];
    logic signed [EQFIR_CW-1:0] coeff_regs_chan_b_q [EQFIR_TAPS];
    logic signed [EQFIR_CW-1:0] coeff_regs_chan_b_d [EQFIR_TAPS];
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] resp_q, resp_d;
    eqfir_mode_t mode;

    logic req;
    logic [31:0] wmask;
    logic [31:0] ctrl_word;
    logic [EQFIR_AW-1:0] idx_a, idx_b;

    assign req = (I_AVS_READ || I_AVS_WRITE) && !ack_q;
    assign wmask = {{8{I_AVS_BYTEENABLE[3]}}, {8{I_AVS_BYTEENABLE[2]}},
                    {8{I_AVS_BYTEENABLE[1]}}, {8{I_AVS_BYTEENABLE[0]}}};
    assign idx_a = (I_AVS_ADDRESS - EQFIR_OFS_COEF_A) >> 2;
    assign idx_b = (I_AVS_ADDRESS - EQFIR_OFS_COEF_B) >> 2;

    always_comb begin
        ctrl_word = '0;
        ctrl_word[EQFIR_MODE_LSB +: 2] = filter_mode_select_q;
        ctrl_word[EQFIR_SHARE_BIT] = coeff_share_q;
        ctrl_word[EQFIR_MERGE_BIT] = channel_merge_q;
        ctrl_word[EQFIR_SHIFT_LSB +: 3] = shift_q;
        ctrl_word[EQFIR_LINK_LSB +: 2] = link_mode_select_q;
        ctrl_word[EQFIR_SINGLE_BIT] = single_input_q;
    end

    always_comb begin
        logic [31:0] nw;
        nw = '0;
        filter_mode_select_d = filter_mode_select_q;
        coeff_share_d = coeff_share_q;
        channel_merge_d = channel_merge_q;
        shift_d = shift_q;
        link_mode_select_d = link_mode_select_q;
        single_input_d = single_input_q;
        coeff_regs_chan_a_d = coeff_regs_chan_a_q;
        coeff_regs_chan_b_d = coeff_regs_chan_b_q;
        ack_d = req;
        rdata_d = rdata_q;
        resp_d = resp_q;
        if (req) begin
            rdata_d = 32'h0;
            resp_d = 2'h0;
            if (I_AVS_ADDRESS == EQFIR_OFS_CTRL) begin
                nw = (ctrl_word & ~wmask) | (I_AVS_WRITEDATA & wmask);
                rdata_d = ctrl_word;
                if (I_AVS_WRITE) begin
                    filter_mode_select_d = nw[EQFIR_MODE_LSB +: 2]; // [R2]
                    coeff_share_d = nw[EQFIR_SHARE_BIT];
                    channel_merge_d = nw[EQFIR_MERGE_BIT];
                    // a weight above 2^-10 is held at the coarsest legal step, shift 6
                    shift_d = (nw[EQFIR_SHIFT_LSB +: 3] > 3'(EQFIR_NFRAC_MAX - EQFIR_NFRAC_MIN))
                              ? 3'(EQFIR_NFRAC_MAX - EQFIR_NFRAC_MIN) : nw[EQFIR_SHIFT_LSB +: 3]; // [R5]
                    link_mode_select_d = nw[EQFIR_LINK_LSB +: 2];
                    single_input_d = nw[EQFIR_SINGLE_BIT];
                end
            end else if (I_AVS_ADDRESS == EQFIR_OFS_STATUS) begin
                rdata_d = 32'(mode);
            end else if (I_AVS_ADDRESS >= EQFIR_OFS_COEF_A && idx_a < EQFIR_AW'(EQFIR_TAPS)
                         && I_AVS_ADDRESS[1:0] == 2'h0) begin
                rdata_d = 32'(coeff_regs_chan_a_q[idx_a[3:0]]);
                nw = (rdata_d & ~wmask) | (I_AVS_WRITEDATA & wmask);
                if (I_AVS_WRITE) begin
                    coeff_regs_chan_a_d[idx_a[3:0]] = nw[EQFIR_CW-1:0]; // [R9]
                end
            end else if (I_AVS_ADDRESS >= EQFIR_OFS_COEF_B && idx_b < EQFIR_AW'(EQFIR_TAPS)
                         && I_AVS_ADDRESS[1:0] == 2'h0) begin
                rdata_d = 32'(coeff_regs_chan_b_q[idx_b[3:0]]);
                nw = (rdata_d & ~wmask) | (I_AVS_WRITEDATA & wmask);
                if (I_AVS_WRITE) begin
                    coeff_regs_chan_b_d[idx_b[3:0]] = nw[EQFIR_CW-1:0]; // [R9]
                end
            end else begin
                rdata_d = EQFIR_UNMAPPED;
                resp_d = 2'h3;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            filter_mode_select_q <= EQFIR_MODE_OFF;
            coeff_share_q <= 1'b0;
            channel_merge_q <= 1'b0;
            shift_q <= EQFIR_SHIFT_RST;
            link_mode_select_q <= EQFIR_LINK_DUAL;
            single_input_q <= 1'b0;
            coeff_regs_chan_a_q <= '{default: '0};
            coeff_regs_chan_b_q <= '{default: '0};
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
            resp_q <= 2'h0;
        end else begin
            filter_mode_select_q <= filter_mode_select_d;
            coeff_share_q <= coeff_share_d;
            channel_merge_q <= channel_merge_d;
            shift_q <= shift_d;
            link_mode_select_q <= link_mode_select_d;
            single_input_q <= single_input_d;
            coeff_regs_chan_a_q <= coeff_regs_chan_a_d;
            coeff_regs_chan_b_q <= coeff_regs_chan_b_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            resp_q <= resp_d;
        end
    end

    assign O_AVS_WAITREQUEST = (I_AVS_READ || I_AVS_WRITE) && !ack_q;
    assign O_AVS_READDATA = rdata_q;
    assign O_AVS_RESPONSE = resp_q;

    // ==========================================================
    // mode decode
    // ==========================================================
    // any combination outside the legal table, or a link mode that does
    // not suit it, falls back to bypass rather than filtering wrongly
    always_comb begin
        mode = EQ_BYPASS; // [R2]
        if (filter_mode_select_q == EQFIR_MODE_ON) begin
            if (!coeff_share_q && !channel_merge_q && link_mode_select_q == EQFIR_LINK_DUAL) begin
                mode = EQ_DUAL; // [R3]
            end else if (coeff_share_q && channel_merge_q && link_mode_select_q == EQFIR_LINK_SINGLE) begin
                mode = EQ_SINGLE; // [R7]
            end else if (!coeff_share_q && channel_merge_q && link_mode_select_q == EQFIR_LINK_SINGLE
                         && !single_input_q) begin
                mode = EQ_TVAR; // [R8]
            end
        end
    end

    // ==========================================================
    // coefficient alignment to a common 2^-16 grid
    // ==========================================================
    logic signed [KW-1:0] ka [EQFIR_TAPS];
    logic signed [KW-1:0] kb [EQFIR_TAPS];
    genvar g;
    generate
        for (g = 0; g < EQFIR_TAPS; g++) begin : g_align
            if (g == EQFIR_CENTER) begin : g_c
                assign ka[g] = KW'(coeff_regs_chan_a_q[g]); // [R4]
                assign kb[g] = KW'(coeff_regs_chan_b_q[g]);
            end else begin : g_n
                // one shift for all outer taps: weight 2^-(16-shift)
                assign ka[g] = KW'($signed(coeff_regs_chan_a_q[g][EQFIR_NW-1:0])) <<< shift_q; // [R5] [R6]
                assign kb[g] = KW'($signed(coeff_regs_chan_b_q[g][EQFIR_NW-1:0])) <<< shift_q; // [R6]
            end
        end
    endgenerate

    // ==========================================================
    // datapath
    // ==========================================================
    // lane a carries the even sample of the interleaved pair, lane b the odd
    logic signed [SW-1:0] da_q [EQFIR_TAPS], da_d [EQFIR_TAPS];
    logic signed [SW-1:0] db_q [EQFIR_TAPS], db_d [EQFIR_TAPS];
    logic signed [SW-1:0] xa [EQFIR_TAPS], xb [EQFIR_TAPS];
    logic signed [KW-1:0] kpa [EQFIR_TAPS], kpb [EQFIR_TAPS];
    logic signed [AW-1:0] suma, sumb;
    logic signed [SW-1:0] ra, rb;
    logic vld_q, vld_d;
    eqfir_smp_t out_q, out_d;
    eqfir_smp_t byp_q, byp_d;

    always_comb begin
        da_d = da_q;
        db_d = db_q;
        vld_d = I_SMP.valid; // [R13]
        byp_d = I_SMP;
        if (I_SMP.valid) begin
            for (int t = EQFIR_TAPS - 1; t > 0; t--) begin
                da_d[t] = da_q[t-1];
                db_d[t] = db_q[t-1];
            end
            da_d[0] = I_SMP.a;
            db_d[0] = I_SMP.b;
        end
    end

    // in merged modes the interleaved stream is a,b,a,b; each output
    // sees a window of the merged line ending at its own sample
    always_comb begin
        for (int t = 0; t < EQFIR_TAPS; t++) begin
            xa[t] = da_q[t];
            xb[t] = db_q[t];
            kpa[t] = ka[t];
            kpb[t] = kb[t];
            if (mode == EQ_SINGLE || mode == EQ_TVAR) begin
                xa[t] = (t % 2 == 0) ? da_q[t/2] : db_q[t/2 + 1];
                xb[t] = (t % 2 == 0) ? db_q[t/2] : da_q[t/2];
                kpb[t] = (mode == EQ_SINGLE) ? ka[t] : kb[t]; // [R7] [R8]
            end
        end
    end

    eqfir_tap #(.SW(SW), .KW(KW), .AW(AW)) u_tap_a (
        .i_x(xa),
        .i_k(kpa),
        .o_sum(suma)
    );
    eqfir_tap #(.SW(SW), .KW(KW), .AW(AW)) u_tap_b (
        .i_x(xb),
        .i_k(kpb),
        .o_sum(sumb)
    );
    eqfir_round #(.IW(AW), .FRAC(EQFIR_CFRAC), .OW(SW)) u_rnd_a (
        .i_acc(suma),
        .o_res(ra)
    );
    eqfir_round #(.IW(AW), .FRAC(EQFIR_CFRAC), .OW(SW)) u_rnd_b (
        .i_acc(sumb),
        .o_res(rb)
    );

    always_comb begin
        out_d.valid = vld_q;
        if (mode == EQ_BYPASS) begin
            out_d.a = byp_q.a; // [R13]
            out_d.b = byp_q.b;
        end else begin
            out_d.a = ra; // [R1] [R11]
            out_d.b = rb;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            da_q <= '{default: '0};
            db_q <= '{default: '0};
            vld_q <= '0;
            byp_q <= '0;
            out_q <= '0;
        end else begin
            da_q <= da_d;
            db_q <= db_d;
            vld_q <= vld_d;
            byp_q <= byp_d;
            out_q <= out_d;
        end
    end

    assign O_SMP = out_q;
endmodule // eqfir_top

/* File: testbench/eqfir_properties.sv */
// checker for the equalizer top: bus handshake, status decode, sample timing
// assumes it is bound to eqfir_top and sees only its ports
`timescale 1ns/1ps
module eqfir_properties import eqfir_pkg::*; (
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic [EQFIR_AW-1:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic [1:0] O_AVS_RESPONSE,
    input wire eqfir_smp_t I_SMP,
    input wire eqfir_smp_t O_SMP
);
    // ==========
    // control shadow
    logic [15:0] ctrl_q, ctrl_d;
    logic acc_r, acc_w, mapped;
    assign acc_r = I_AVS_READ && !O_AVS_WAITREQUEST;
    assign acc_w = I_AVS_WRITE && !O_AVS_WAITREQUEST;
    assign mapped = I_AVS_ADDRESS inside {EQFIR_OFS_CTRL, EQFIR_OFS_STATUS} || (I_AVS_ADDRESS[1:0] == 2'h0
        && ((I_AVS_ADDRESS >= 8'h40 && I_AVS_ADDRESS <= 8'h60) || (I_AVS_ADDRESS >= 8'h80 && I_AVS_ADDRESS <= 8'hA0)));
    always_comb begin
        ctrl_d = ctrl_q;
        for (int i = 0; i < 2; i++) begin
            if (acc_w && I_AVS_ADDRESS == EQFIR_OFS_CTRL && I_AVS_BYTEENABLE[i]) begin
                ctrl_d[i*8 +: 8] = I_AVS_WRITEDATA[i*8 +: 8];
            end
        end
    end
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ctrl_q <= 16'h0000;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end
    // unsupported combinations fall back to bypass
    function automatic logic [3:0] st_exp(input logic [15:0] c);
        if (c[1:0] != EQFIR_MODE_ON) return 4'h1;
        if (c[5:4] == 2'h0 && c[13:12] == EQFIR_LINK_DUAL) return 4'h2;
        if (c[5:4] == 2'h3 && c[13:12] == EQFIR_LINK_SINGLE) return 4'h4;
        if (c[5:4] == 2'h2 && c[13:12] == EQFIR_LINK_SINGLE && !c[14]) return 4'h8;
        return 4'h1;
    endfunction
    // ==========
    // properties
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);
    AST_WAIT_ONE: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
        else $error("waitrequest held past one cycle");
    AST_UNMAPPED: assert property (acc_r && !mapped |-> O_AVS_READDATA == EQFIR_UNMAPPED && O_AVS_RESPONSE == 2'h3)
        else $error("unmapped read not refused");
    AST_MAPPED_OK: assert property (acc_r && mapped |-> O_AVS_RESPONSE == 2'h0)
        else $error("mapped read flagged");
    AST_STATUS: assert property (acc_r && I_AVS_ADDRESS == EQFIR_OFS_STATUS |-> O_AVS_READDATA == {28'h0, st_exp(ctrl_q)})
        else $error("status mode wrong");
    AST_RD_HOLD: assert property (!(I_AVS_READ || I_AVS_WRITE) |=> $stable(O_AVS_READDATA) && $stable(O_AVS_RESPONSE))
        else $error("read data moved while idle");
    AST_LATENCY: assert property (O_SMP.valid == $past(I_SMP.valid, 2))
        else $error("output valid not two cycles after input");
    AST_ONE_OUT: assert property (I_SMP.valid ##1 !I_SMP.valid |-> ##1 O_SMP.valid ##1 !O_SMP.valid)
        else $error("lone input did not give lone output");
    AST_QUIET: assert property ($rose(I_RESETN) |-> !O_SMP.valid [*3])
        else $error("output without input after reset");
    COV_TVAR: cover property (acc_r && I_AVS_ADDRESS == EQFIR_OFS_STATUS && O_AVS_READDATA[3]);
    COV_UNMAPPED: cover property (acc_r && !mapped);
    COV_BURST: cover property (I_SMP.valid [*4]);
endmodule // eqfir_properties

bind eqfir_top eqfir_properties eqfir_properties_inst (.I_CLK(I_CLK), .I_RESETN(I_RESETN),
    .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
    .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .O_AVS_READDATA(O_AVS_READDATA),
    .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_AVS_RESPONSE(O_AVS_RESPONSE), .I_SMP(I_SMP), .O_SMP(O_SMP));

/* File: testbench/eqfir_src.sv */
// converter-side sample source feeding the equalizer
// assumes the bench enables it only once the filter is configured
`timescale 1ns/1ps
module eqfir_src import eqfir_pkg::*; (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_en,
    input wire logic i_dense,
    input wire logic i_full,
    output eqfir_smp_t o_smp
);
    int seed = 75;
    initial o_smp = '0;
    // idle lanes flip so a filter reading stale lanes is caught
    always @(posedge i_clk) begin
        if (i_resetn && i_en && (i_dense || ($random(seed) & 32'h1))) begin
            o_smp.valid <= 1'b1;
            o_smp.a <= i_full ? (($random(seed) & 32'h1) ? 12'h7FF : 12'h800) : 12'($random(seed));
            o_smp.b <= i_full ? (($random(seed) & 32'h1) ? 12'h800 : 12'h7FF) : 12'($random(seed));
        end else begin
            o_smp.valid <= 1'b0;
            o_smp.a <= ~o_smp.a;
            o_smp.b <= ~o_smp.b;
        end
    end
endmodule // eqfir_src

/* File: testbench/eqfir_top_tb.sv */
// self-checking bench for the equalizer: register setup per mode, streamed samples
// assumes the package map and a fixed-latency sample pipeline
`timescale 1ns/1ps
module eqfir_top_tb import eqfir_pkg::*;;
    logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, src_en = 1'b0, dense = 1'b0, full = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rdata, q;
    logic [3:0] be = 4'hF;
    logic wreq;
    logic [1:0] resp;
    logic [23:0] e;
    eqfir_smp_t smp_in, smp_out;
    int error_cnt = 0, n_tests = 0, seed = 75, nout = 0, sh = 0;
    int co [2][9];
    logic signed [11:0] ha [9], hb [9];
    eqfir_mode_t mode = EQ_BYPASS;
    logic [23:0] eq [$];
    logic [15:0] cfg [9] = '{16'h0030, 16'h0002, 16'h1032, 16'h1022, 16'h0032, 16'h5022, 16'h1002, 16'h0002,
                             16'h5032};
    eqfir_mode_t md [9] = '{EQ_BYPASS, EQ_DUAL, EQ_SINGLE, EQ_TVAR, EQ_BYPASS, EQ_BYPASS, EQ_BYPASS, EQ_DUAL,
                            EQ_SINGLE};

    initial forever #5 clk = ~clk;
    eqfir_top eqfir_top_inst (.I_CLK(clk), .I_RESETN(rstn), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
        .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq),
        .O_AVS_RESPONSE(resp), .I_SMP(smp_in), .O_SMP(smp_out));
    eqfir_src eqfir_src_inst (.i_clk(clk), .i_resetn(rstn), .i_en(src_en), .i_dense(dense), .i_full(full),
        .o_smp(smp_in));

    // ==========
    // checking and bus helpers
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // waitrequest and read data are taken at the rising edge, before that edge's updates land
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] m,
                       output logic [31:0] r);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        be <= m;
        do @(posedge clk); while (wreq !== 1'b0);
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // ==========
    // reference filter
    function automatic logic [11:0] fir(input bit lb);
        longint acc, qq, rr;
        logic signed [11:0] x;
        bit sb;
        if (mode == EQ_BYPASS) return lb ? hb[0] : ha[0];
        acc = 0;
        sb = lb && mode != EQ_SINGLE;
        for (int k = 0; k < 9; k++) begin
            if (mode == EQ_DUAL) x = lb ? hb[k] : ha[k];
            else if (k % 2 == 0) x = lb ? hb[k/2] : ha[k/2];
            else x = lb ? ha[k/2] : hb[k/2+1];
            acc += x * ((k == 4) ? longint'(co[sb][k]) : longint'(co[sb][k]) <<< sh);
        end
        qq = acc >>> 16;
        rr = acc & 64'hFFFF;
        if (rr > 32768 || (rr == 32768 && qq[0])) qq++;
        return qq > 2047 ? 12'h7FF : (qq < -2048 ? 12'h800 : qq[11:0]);
    endfunction
    always @(posedge clk) begin
        if (smp_out.valid === 1'b1) begin
            if (eq.size() == 0) chk(1'b0, "output without input");
            else begin
                e = eq.pop_front();
                if (nout >= 9) chk({smp_out.a, smp_out.b} === e, "filtered sample");
                nout++;
            end
        end
        if (smp_in.valid === 1'b1 && rstn) begin
            for (int k = 8; k > 0; k--) begin
                ha[k] = ha[k-1];
                hb[k] = hb[k-1];
            end
            ha[0] = smp_in.a;
            hb[0] = smp_in.b;
            eq.push_back({fir(1'b0), fir(1'b1)});
        end
    end
    // ==========
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        for (int c = 0; c < 9; c++) begin
            rstn <= 1'b0;
            @(posedge clk);
            rstn <= 1'b1;
            eq.delete();
            nout = 0;
            ha = '{default: '0};
            hb = '{default: '0};
            mode = md[c];
            sh = $random(seed) & 32'h7;
            for (int s = 0; s < 2; s++) begin
                for (int k = 0; k < 9; k++) begin
                    co[s][k] = (k == 4) ? $random(seed) % 131072 : $random(seed) % 2048;
                    if (c == 7) co[s][k] = (k == 4) ? 32768 : 0;
                    bus(1'b1, 8'h40 + 8'(s * 64 + k * 4), 32'(co[s][k]), 4'hF, q);
                    bus(1'b0, 8'h40 + 8'(s * 64 + k * 4), 32'h0, 4'hF, q);
                    chk(q[17:0] === co[s][k][17:0], "coefficient readback");
                end
            end
            bus(1'b1, EQFIR_OFS_CTRL, {16'h0, cfg[c]} | 32'(sh << 8), 4'hF, q);
            bus(1'b1, EQFIR_OFS_CTRL, 32'hFFFFFFFF, 4'h0, q);
            bus(1'b1, EQFIR_OFS_STATUS, 32'hFFFFFFFF, 4'hF, q);
            bus(1'b0, EQFIR_OFS_STATUS, 32'h0, 4'hF, q);
            chk(q === 32'(md[c]), "mode status");
            bus(1'b0, 8'h3C, 32'h0, 4'hF, q);
            chk(q === EQFIR_UNMAPPED && resp === 2'h3, "unmapped read");
            if (sh > 6) sh = 6;
            src_en <= 1'b1;
            dense <= 1'b1;
            repeat (40) @(posedge clk);
            dense <= 1'b0;
            repeat (40) @(posedge clk);
            full <= 1'b1;
            repeat (20) @(posedge clk);
            full <= 1'b0;
            src_en <= 1'b0;
            repeat (6) @(posedge clk);
            chk(eq.size() == 0, "missing outputs");
        end
        close_out();
    end
    initial begin
        #200000;
        error_cnt++;
        $display("[ERR] %0t run timed out", $time);
        close_out();
    end
endmodule // eqfir_top_tb
